// File: include/pfs_consts.svh
// Shared constants for the point-of-load fault supervisor and its power manager host
// Notes on behaviour
// - Above 120C: warning, flag low, maybe notify
// - Warning withdrawn below 117C, giving hysteresis
// - Warnings never switch the output off
// - Pull power good low outside window
// - Window armed in steady state only
// - Power good warning: pin low, flag low
// - Back in window: release pin, flag high
// - Foreign low on power good pin warns
// - Any fault turns the converter output off
// - Current limit plus undervoltage: fast overcurrent off
// - Setup bit disables current limit temperature compensation
// - Steady-state undervoltage without overcurrent: ramped off
// - Above 130C while powered: ramped turn-off
// - Non-latching overtemperature restarts below 120C warning
// - Ramp-up tracking error over 250mV: fast off
// - Tracking protection enable bit, when clear, blocks tracking faults
// - Overvoltage: high side off, low side on
// - Overvoltage threshold 110-130 percent, at least 1.0V
// - Phase voltage error never raised here
// - Host polls status continuously when monitoring enabled
// - Propagation lets a fault turn others off
// - Non-latching: retry every 130ms until cause gone
// - Latching: stay off until cleared or recycled
`ifndef PFS_CONSTS_SVH
`define PFS_CONSTS_SVH
// Status word bit positions, flags are active low
`define PFS_B_TEMPW 7
`define PFS_B_PG 6
`define PFS_B_TR 5
`define PFS_B_OT 4
`define PFS_B_OC 3
`define PFS_B_UV 2
`define PFS_B_OV 1
`define PFS_B_PV 0
`define PFS_STATUS_IDLE 8'hff
// Fault bits that the host can clear, warnings excluded
`define PFS_FAULT_MASK 8'h3f
// Protection type register: tracking enable, latching bits share status positions
`define PFS_PT_TRE 7
`define PFS_PT_RESET 8'h43
// Fault reporting register: warning report enables, propagation enables below
`define PFS_FR_WARN_HI 7
`define PFS_FR_WARN_LO 6
`define PFS_FR_PROP_MASK 8'h3f
`define PFS_FR_RESET 8'h3f
// Limits register: power good low select and overvoltage level select
`define PFS_LIM_PGLL 4
`define PFS_LIM_OV_HI 3
`define PFS_LIM_OV_LO 2
`define PFS_LIM_RESET 8'h08
// Current limit setup register: compensation disable bit
`define PFS_CLS_TCOMP_DIS 7
`define PFS_CLS_RESET 8'h00
// Timing
`define PFS_CLK_MHZ 125
`define PFS_RETRY_MS 130
`define PFS_RETRY_CYC (`PFS_RETRY_MS * 1000 * `PFS_CLK_MHZ)
`define PFS_POLL_GAP 16
`endif

// File: include/pfs_pkg.sv
// Types shared by both ends of the fault supervisor link
package pfs_pkg;
	// Supervisor main states
	typedef enum logic [1:0] {PFS_OFF, PFS_RUN, PFS_PROT} pfs_state_e;

	// Whole device-end state
	typedef struct packed {
		pfs_state_e state;
		logic temp_warn;
		logic [7:0] flags;
		logic [7:0] cause;
		logic prop_cause;
		logic [31:0] timer;
		logic timed_out;
		logic recycled;
		logic turn_on_q;
		logic powered_q;
		logic pg_oe;
		logic ok_oe;
		logic mod_en;
		logic ls_force;
		logic ramp_down;
		logic tcomp_en;
		logic [7:0] status_word;
		logic status_valid;
		logic alert;
	} pfs_dev_s;

	// Whole host-end state
	typedef struct packed {
		logic [7:0] poll_cnt;
		logic poll_req;
		logic clear_req;
		logic [7:0] clear_mask;
		logic [7:0] prot_type;
		logic [7:0] fault_rep;
		logic [7:0] limits;
		logic [7:0] current_limit_setup_reg;
		logic pg_ext_oe;
		logic ok_ext_oe;
		logic [7:0] status;
		logic status_fresh;
		logic alert_seen;
	} pfs_host_s;
endpackage : pfs_pkg

// File: include/pfs_if.sv
// Link between the supervisor and the power manager host, with both open-drain lines
`timescale 1ns/1ps
interface pfs_if;
	// Host to device configuration and requests
	logic [7:0] prot_type;
	logic [7:0] fault_rep;
	logic [7:0] limits;
	logic [7:0] current_limit_setup_reg;
	logic poll_req;
	logic clear_req;
	logic [7:0] clear_mask;
	// Device to host answers
	logic [7:0] status_word;
	logic status_valid;
	logic alert;
	// Open-drain enables and resolved levels
	logic pg_oe;
	logic pg_ext_oe;
	logic ok_oe;
	logic ok_ext_oe;
	logic pg_line;
	logic ok_line;

	// Wired-and: any enabled driver pulls the line low
	assign pg_line = ~(pg_oe | pg_ext_oe);
	assign ok_line = ~(ok_oe | ok_ext_oe);

	modport dev (
		input prot_type, fault_rep, limits, current_limit_setup_reg, poll_req, clear_req, clear_mask,
		input pg_line, ok_line,
		output status_word, status_valid, alert, pg_oe, ok_oe
	);
	modport host (
		output prot_type, fault_rep, limits, current_limit_setup_reg, poll_req, clear_req, clear_mask,
		output pg_ext_oe, ok_ext_oe,
		input status_word, status_valid, alert, pg_line, ok_line
	);
endinterface : pfs_if

// File: src/pfs_host.sv
// Power manager host end: configuration, status polling and external line pulls
`timescale 1ns/1ps
`include "pfs_consts.svh"
module pfs_host import pfs_pkg::*; #(
	parameter int POLL_GAP = `PFS_POLL_GAP
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Link
	pfs_if.host lnk,
	// User configuration
	input wire logic poll_en,
	input wire logic [7:0] prot_type_in,
	input wire logic [7:0] fault_rep_in,
	input wire logic [7:0] limits_in,
	input wire logic [7:0] cls_in,
	// User clear request, one-cycle strobe with mask
	input wire logic clear_strobe,
	input wire logic [7:0] clear_mask_in,
	// External pulls on the shared lines
	input wire logic pg_pull_low,
	input wire logic ok_pull_low,
	// User status view
	output logic [7:0] status,
	output logic status_fresh,
	output logic alert_seen
);
	// Poll counter is eight bits wide, so the gap must fit in it
	if (POLL_GAP < 1 || POLL_GAP > 255) begin : g_bad_gap
		$error("POLL_GAP out of range");
	end

	pfs_host_s r, n; // Registered state and its next value

	// Next-state logic
	always_comb begin
		n = r;
		n.poll_req = 1'b0;
		n.clear_req = clear_strobe;
		n.clear_mask = clear_mask_in;
		n.prot_type = prot_type_in;
		n.fault_rep = fault_rep_in;
		n.limits = limits_in;
		n.current_limit_setup_reg = cls_in;
		n.pg_ext_oe = pg_pull_low;
		n.ok_ext_oe = ok_pull_low;
		n.status_fresh = 1'b0;
		n.alert_seen = lnk.alert;
		// Poll at a fixed gap while monitoring is on
		if (!poll_en) begin
			n.poll_cnt = 8'h00;
		end else if (r.poll_cnt == 8'h00) begin
			n.poll_req = 1'b1;
			n.poll_cnt = 8'(POLL_GAP - 1);
		end else begin
			n.poll_cnt = r.poll_cnt - 8'h01;
		end
		// Capture each answer
		if (lnk.status_valid) begin
			n.status = lnk.status_word;
			n.status_fresh = 1'b1;
		end
	end

	// State register
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			r <= '0;
			r.prot_type <= `PFS_PT_RESET;
			r.fault_rep <= `PFS_FR_RESET;
			r.limits <= `PFS_LIM_RESET;
			r.current_limit_setup_reg <= `PFS_CLS_RESET;
			r.status <= `PFS_STATUS_IDLE;
		end else begin
			r <= n;
		end
	end

	// Port drive straight from flops
	assign lnk.poll_req = r.poll_req;
	assign lnk.clear_req = r.clear_req;
	assign lnk.clear_mask = r.clear_mask;
	assign lnk.prot_type = r.prot_type;
	assign lnk.fault_rep = r.fault_rep;
	assign lnk.limits = r.limits;
	assign lnk.current_limit_setup_reg = r.current_limit_setup_reg;
	assign lnk.pg_ext_oe = r.pg_ext_oe;
	assign lnk.ok_ext_oe = r.ok_ext_oe;
	assign status = r.status;
	assign status_fresh = r.status_fresh;
	assign alert_seen = r.alert_seen;
endmodule : pfs_host

// File: src/pfs_dev.sv
// Device end: protection classification, status flags, power good and restart control
`timescale 1ns/1ps
`include "pfs_consts.svh"
module pfs_dev import pfs_pkg::*; #(
	parameter int RETRY_CYC = `PFS_RETRY_CYC
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Link to the host
	pfs_if.dev lnk,
	// Operating phase
	input wire logic powered,
	input wire logic turn_on,
	input wire logic ramp_up,
	input wire logic steady,
	input wire logic ramp_done,
	input wire logic above_prebias,
	// Temperature comparators
	input wire logic temp_above_120,
	input wire logic temp_below_117,
	input wire logic temp_above_130,
	// Output voltage comparators
	input wire logic vout_above_pg_high,
	input wire logic vout_below_pg_90,
	input wire logic vout_below_pg_95,
	input wire logic vout_below_uv,
	input wire logic [2:0] vout_above_ov,
	input wire logic vout_above_1v0,
	// Current and tracking comparators
	input wire logic i_at_limit,
	input wire logic track_err_250mv,
	// Converter control
	output logic mod_en,
	output logic ls_force,
	output logic ramp_down,
	output logic tcomp_en
);
	// Timer is 32 bits wide and must count at least one cycle
	if (RETRY_CYC < 1) begin : g_bad_retry
		$error("RETRY_CYC must be at least 1");
	end

	pfs_dev_s r, n; // Registered state and its next value

	logic pg_bad; // Window or phase says power is not good
	logic pg_warn; // Power good warning including foreign pull
	logic ov_trip; // Selected overvoltage level crossed
	logic [7:0] ev; // Events of this cycle, bit set means flag goes low
	logic prop_ev; // Group line pulled low by someone else
	logic [7:0] gone; // Cause no longer present, per bit
	logic [7:0] cleared; // Fault flags that may be cleared this cycle
	logic [7:0] rep_mask; // Flags whose fall notifies the host
	logic cause_gone; // All latched causes have gone away
	logic may_restart; // Restart gate for the current cause
	logic armed; // Output is running and protections may trip

	// Next-state logic
	always_comb begin
		n = r;
		n.status_valid = 1'b0;
		n.alert = 1'b0;
		n.recycled = r.recycled;
		n.turn_on_q = turn_on;
		n.powered_q = powered;
		n.tcomp_en = ~lnk.current_limit_setup_reg[`PFS_CLS_TCOMP_DIS];
		armed = (r.state == PFS_RUN);

		// Temperature warning with hysteresis, never touches the output
		if (temp_above_120) begin
			n.temp_warn = 1'b1;
		end else if (temp_below_117) begin
			n.temp_warn = 1'b0;
		end

		// Power good: forced bad outside steady running, then window checked
		pg_bad = ~(armed & steady);
		if (lnk.limits[`PFS_LIM_PGLL]) begin
			pg_bad = pg_bad | vout_above_pg_high | vout_below_pg_95;
		end else begin
			pg_bad = pg_bad | vout_above_pg_high | vout_below_pg_90;
		end
		n.pg_oe = pg_bad;
		// A low line we are not pulling is a foreign warning
		pg_warn = pg_bad | (~lnk.pg_line & ~r.pg_oe);

		// Overvoltage level select; the top code repeats the highest level
		case (lnk.limits[`PFS_LIM_OV_HI:`PFS_LIM_OV_LO])
			2'h0: ov_trip = vout_above_ov[0];
			2'h1: ov_trip = vout_above_ov[1];
			default: ov_trip = vout_above_ov[2];
		endcase
		ov_trip = ov_trip & vout_above_1v0;

		// Event vector
		ev = 8'h00;
		ev[`PFS_B_OV] = armed & above_prebias & ov_trip;
		ev[`PFS_B_OC] = armed & above_prebias & i_at_limit & vout_below_uv;
		ev[`PFS_B_UV] = armed & steady & vout_below_uv & ~ev[`PFS_B_OC];
		ev[`PFS_B_OT] = powered & temp_above_130;
		ev[`PFS_B_TR] = armed & ramp_up & track_err_250mv
			& lnk.prot_type[`PFS_PT_TRE];
		ev[`PFS_B_PV] = 1'b0;
		prop_ev = armed & ~lnk.ok_line & ~r.ok_oe;

		// Flags: host clears fault bits, a new event in the same cycle wins
		cleared = lnk.clear_req ? (lnk.clear_mask & `PFS_FAULT_MASK) : 8'h00;
		n.flags = (r.flags | cleared) & ~ev;
		n.flags[`PFS_B_TEMPW] = ~n.temp_warn;
		n.flags[`PFS_B_PG] = ~pg_warn;
		n.flags[`PFS_B_PV] = 1'b1;

		// Notify on falling flags; faults always, warnings when enabled
		rep_mask = `PFS_FAULT_MASK;
		rep_mask[`PFS_B_TEMPW] = lnk.fault_rep[`PFS_FR_WARN_HI];
		rep_mask[`PFS_B_PG] = lnk.fault_rep[`PFS_FR_WARN_LO];
		n.alert = |(r.flags & ~n.flags & rep_mask);

		// Status answer to a poll, one cycle later
		if (lnk.poll_req) begin
			n.status_word = r.flags;
			n.status_valid = 1'b1;
		end

		// Turn-on or input power recycle, remembered while protected
		if ((r.turn_on_q & ~turn_on) | (r.powered_q & ~powered)) begin
			n.recycled = 1'b1;
		end

		// Per-cause removal test
		gone = 8'hff;
		gone[`PFS_B_OV] = ~ov_trip;
		gone[`PFS_B_OC] = ~i_at_limit;
		gone[`PFS_B_UV] = ~vout_below_uv;
		gone[`PFS_B_OT] = ~temp_above_120;
		cause_gone = ((r.cause & ~gone) == 8'h00) & (~r.prop_cause | lnk.ok_line);
		// Latching causes need a cleared flag or a recycle
		if ((r.cause & lnk.prot_type & `PFS_FAULT_MASK) == 8'h00) begin
			may_restart = 1'b1;
		end else begin
			may_restart = ((r.flags & r.cause) == r.cause) | r.recycled;
		end

		case (r.state)
			PFS_OFF: begin
				n.mod_en = 1'b0;
				n.ls_force = 1'b0;
				n.ramp_down = 1'b0;
				n.ok_oe = 1'b0;
				if (turn_on & powered & ~temp_above_130) begin
					n.state = PFS_RUN;
					n.mod_en = 1'b1;
				end
			end
			PFS_RUN: begin
				n.recycled = 1'b0;
				n.timer = 32'h0;
				n.timed_out = 1'b0;
				if ((ev != 8'h00) | prop_ev) begin
					// Any fault or error stops the output
					n.state = PFS_PROT;
					n.cause = ev;
					n.prop_cause = prop_ev;
					n.ok_oe = |(ev & lnk.fault_rep & `PFS_FR_PROP_MASK);
					if (ev[`PFS_B_OV]) begin
						n.mod_en = 1'b0;
						n.ls_force = 1'b1;
					end else if (ev[`PFS_B_OC] | ev[`PFS_B_TR]) begin
						n.mod_en = 1'b0;
					end else begin
						n.ramp_down = 1'b1;
					end
				end else if (~turn_on | ~powered) begin
					// Commanded turn-off ramps down
					n.state = PFS_PROT;
					n.cause = 8'h00;
					n.prop_cause = 1'b0;
					n.ramp_down = 1'b1;
				end
			end
			PFS_PROT: begin
				// Regular turn-off ends when the ramp reaches zero
				if (r.ramp_down & ramp_done) begin
					n.ramp_down = 1'b0;
					n.mod_en = 1'b0;
				end
				// Retry spacing
				if (r.timer >= 32'(RETRY_CYC - 1)) begin
					n.timed_out = 1'b1;
				end else begin
					n.timer = r.timer + 32'h1;
				end
				if (r.cause == 8'h00 & ~r.prop_cause & ~r.ramp_down) begin
					// Plain turn-off finished
					n.state = PFS_OFF;
				end else if (turn_on & powered & cause_gone & may_restart & ~r.ramp_down
					& (r.timed_out | (r.cause == (8'h01 << `PFS_B_OT)
					& ~lnk.prot_type[`PFS_B_OT]))) begin
					// Restart through the normal ramp
					n.state = PFS_RUN;
					n.cause = 8'h00;
					n.prop_cause = 1'b0;
					n.mod_en = 1'b1;
					n.ls_force = 1'b0;
					n.ok_oe = 1'b0;
				end
			end
			default: begin
				n.state = PFS_OFF;
			end
		endcase
	end

	// State register
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			r <= '0;
			r.state <= PFS_OFF;
			r.flags <= `PFS_STATUS_IDLE;
			r.status_word <= `PFS_STATUS_IDLE;
			r.pg_oe <= 1'b1;
			r.tcomp_en <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// Port drive straight from flops
	assign lnk.status_word = r.status_word;
	assign lnk.status_valid = r.status_valid;
	assign lnk.alert = r.alert;
	assign lnk.pg_oe = r.pg_oe;
	assign lnk.ok_oe = r.ok_oe;
	assign mod_en = r.mod_en;
	assign ls_force = r.ls_force;
	assign ramp_down = r.ramp_down;
	assign tcomp_en = r.tcomp_en;
endmodule : pfs_dev

// File: tb/pfs_checker.sv
// Link checker for the supervisor status answers and the shared lines
`timescale 1ns/1ps
module pfs_checker (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Host side of the link
	input wire logic [7:0] fault_rep,
	input wire logic poll_req,
	input wire logic pg_ext_oe,
	// Device side of the link
	input wire logic [7:0] status_word,
	input wire logic status_valid,
	input wire logic pg_oe,
	input wire logic ok_oe,
	input wire logic pg_line
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// Line held long enough that the flag must follow it at the poll
	sequence pg_low_held; (!pg_line)[*4] ##0 poll_req; endsequence
	sequence pg_high_held; pg_line[*4] ##0 poll_req; endsequence
	sequence pg_ext_held; (pg_ext_oe && !pg_oe)[*4] ##0 poll_req; endsequence
	poll_answer_a: assert property (poll_req |=> status_valid)
		else $error("poll not answered");
	valid_cause_a: assert property (status_valid |-> $past(poll_req))
		else $error("answer without poll");
	word_hold_a: assert property (!status_valid |-> $stable(status_word))
		else $error("status word moved between polls");
	phase_bit_a: assert property (status_valid |-> status_word[0])
		else $error("phase error reported");
	pg_foreign_a: assert property (pg_ext_held |=> !status_word[6])
		else $error("foreign pull not flagged");
	pg_low_a: assert property (pg_low_held |=> !status_word[6])
		else $error("low power good not flagged");
	pg_release_a: assert property (pg_high_held |=> status_word[6])
		else $error("power good flag not released");
	ok_prop_a: assert property ($rose(ok_oe) |-> fault_rep[5:0] != 6'h00)
		else $error("group line pulled without propagation");
endmodule : pfs_checker

// File: tb/pol_fault_supervisor_tb_top.sv
// Bench joining both supervisor ends and driving protection scenarios
`timescale 1ns/1ps
module pol_fault_supervisor_tb_top;
	// Clock, reset and counters
	logic clock = 0;
	logic rst = 1;
	int n_fail = 0;
	int check_count = 0;
	// Device user side, all quiet at time zero
	logic powered = 0, turn_on = 0, ramp_up = 0, steady = 0, ramp_done = 1;
	logic above_prebias = 0, temp_above_120 = 0, temp_below_117 = 1, temp_above_130 = 0;
	logic vout_above_pg_high = 0, vout_below_pg_90 = 0, vout_below_pg_95 = 0, vout_below_uv = 0;
	logic [2:0] vout_above_ov = 3'h0;
	logic vout_above_1v0 = 0, i_at_limit = 0, track_err_250mv = 0;
	logic mod_en, ls_force, ramp_down, tcomp_en;
	// Host user side
	logic [7:0] prot_type_in = 8'h43, limits_in = 8'h08, cls_in = 8'h00;
	logic clear_strobe = 0, pg_pull_low = 0, ok_pull_low = 0;
	logic [7:0] clear_mask_in = 8'h00, status;
	logic status_fresh, alert_seen;

	always #4 clock = ~clock;

	pfs_if lnk ();
	// Short retry count keeps restart scenarios brief
	pfs_dev #(.RETRY_CYC(20)) i_pfs_dev (.clock, .rst, .lnk(lnk), .powered, .turn_on,
		.ramp_up, .steady, .ramp_done, .above_prebias, .temp_above_120, .temp_below_117,
		.temp_above_130, .vout_above_pg_high, .vout_below_pg_90, .vout_below_pg_95,
		.vout_below_uv, .vout_above_ov, .vout_above_1v0, .i_at_limit, .track_err_250mv,
		.mod_en, .ls_force, .ramp_down, .tcomp_en);
	pfs_host #(.POLL_GAP(4)) i_pfs_host (.clock, .rst, .lnk(lnk), .poll_en(1'b1),
		.prot_type_in, .fault_rep_in(8'h3f), .limits_in, .cls_in, .clear_strobe,
		.clear_mask_in, .pg_pull_low, .ok_pull_low, .status, .status_fresh, .alert_seen);
	pfs_checker i_pfs_checker (.clock, .rst, .fault_rep(lnk.fault_rep),
		.poll_req(lnk.poll_req), .pg_ext_oe(lnk.pg_ext_oe), .status_word(lnk.status_word),
		.status_valid(lnk.status_valid), .pg_oe(lnk.pg_oe), .ok_oe(lnk.ok_oe),
		.pg_line(lnk.pg_line));

	// Verdict and end of run
	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : summarize

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic step(input int n);
		repeat (n) @(negedge clock);
	endtask : step

	// Two fresh answers, so the second reflects inputs set before the call
	task automatic expect_st(input logic [7:0] e);
		int k;
		repeat (2) begin
			k = 0;
			while (status_fresh !== 1'b1 && k < 50) begin
				step(1);
				k++;
			end
			if (k == 50) begin
				n_fail++;
				summarize();
			end
			step(1);
		end
		check(status, e);
	endtask : expect_st

	// Bounded wait for the modulator enable
	task automatic wait_mod(input logic v, input int hi);
		int k;
		k = 0;
		while (mod_en !== v && k < hi) begin
			step(1);
			k++;
		end
		check(8'(mod_en), 8'(v));
		if (mod_en !== v) summarize();
	endtask : wait_mod

	task automatic clr(input logic [7:0] m);
		clear_mask_in = m;
		clear_strobe = 1;
		step(1);
		clear_strobe = 0;
	endtask : clr

	// Ramp to steady state after each start
	task automatic ramp_in;
		steady = 0;
		ramp_up = 1;
		step(3);
		ramp_up = 0;
		steady = 1;
		above_prebias = 1;
	endtask : ramp_in

	initial begin
		repeat (20) @(posedge clock);
		step(1);
		rst = 0;
		expect_st(8'hbf);
		powered = 1;
		turn_on = 1;
		wait_mod(1, 60);
		ramp_in();
		expect_st(8'hff);
		check(8'(lnk.pg_line), 8'h01);
		check(8'(tcomp_en), 8'h01);
		cls_in = 8'h80;
		step(3);
		check(8'(tcomp_en), 8'h00);
		// Warning with hysteresis, output stays on
		temp_above_120 = 1;
		temp_below_117 = 0;
		expect_st(8'h7f);
		check(8'(mod_en), 8'h01);
		temp_above_120 = 0;
		expect_st(8'h7f);
		temp_below_117 = 1;
		expect_st(8'hff);
		pg_pull_low = 1;
		expect_st(8'hbf);
		check(8'(mod_en), 8'h01);
		pg_pull_low = 0;
		// Window low limit follows the select bit
		vout_below_pg_95 = 1;
		expect_st(8'hff);
		limits_in = 8'h18;
		expect_st(8'hbf);
		check(8'(lnk.pg_line), 8'h00);
		// Lower select uses the 90 percent comparator
		limits_in = 8'h08;
		vout_below_pg_90 = 1;
		expect_st(8'hbf);
		vout_below_pg_90 = 0;
		limits_in = 8'h08;
		vout_below_pg_95 = 0;
		vout_above_pg_high = 1;
		expect_st(8'hbf);
		vout_above_pg_high = 0;
		expect_st(8'hff);
		// Tracking blocked while disabled, then a fast trip and timed retry
		steady = 0;
		ramp_up = 1;
		track_err_250mv = 1;
		step(10);
		check(8'(mod_en), 8'h01);
		prot_type_in = 8'hc3;
		wait_mod(0, 5);
		track_err_250mv = 0;
		ramp_up = 0;
		step(10);
		check(8'(mod_en), 8'h00);
		wait_mod(1, 40);
		ramp_in();
		expect_st(8'hdf);
		clr(8'h20);
		expect_st(8'hff);
		// Overvoltage below the selected level or the clamp does not trip
		vout_above_ov = 3'h3;
		vout_above_1v0 = 1;
		step(5);
		check(8'(mod_en), 8'h01);
		vout_above_ov = 3'h7;
		vout_above_1v0 = 0;
		step(5);
		check(8'(mod_en), 8'h01);
		vout_above_1v0 = 1;
		step(2);
		check({6'h00, mod_en, ls_force}, 8'h01);
		check(8'(alert_seen), 8'h01);
		vout_above_ov = 3'h0;
		step(40);
		check(8'(mod_en), 8'h00);
		expect_st(8'hbd);
		clr(8'h02);
		wait_mod(1, 40);
		check(8'(ls_force), 8'h00);
		ramp_in();
		// Overcurrent wins over undervoltage and switches off at once
		i_at_limit = 1;
		vout_below_uv = 1;
		step(2);
		check(8'(mod_en), 8'h00);
		i_at_limit = 0;
		vout_below_uv = 0;
		wait_mod(1, 40);
		ramp_in();
		expect_st(8'hf7);
		clr(8'h08);
		// Undervoltage without current limit ramps down, then a timed retry
		ramp_done = 0;
		vout_below_uv = 1;
		step(2);
		check({6'h00, mod_en, ramp_down}, 8'h03);
		ramp_done = 1;
		vout_below_uv = 0;
		wait_mod(0, 5);
		wait_mod(1, 40);
		ramp_in();
		expect_st(8'hfb);
		clr(8'h04);
		// Overtemperature ramps down first, restarts once below the warning level
		ramp_done = 0;
		temp_above_130 = 1;
		temp_above_120 = 1;
		temp_below_117 = 0;
		step(2);
		check({6'h00, mod_en, ramp_down}, 8'h03);
		ramp_done = 1;
		wait_mod(0, 5);
		check(8'(lnk.ok_line), 8'h00);
		temp_above_130 = 0;
		// Well inside the retry time, so only the warning level can restart it
		step(5);
		check(8'(mod_en), 8'h00);
		temp_above_120 = 0;
		wait_mod(1, 3);
		ramp_in();
		temp_below_117 = 1;
		clr(8'h10);
		expect_st(8'hff);
		// A foreign pull on the group line stops the output, retry after release
		ok_pull_low = 1;
		wait_mod(0, 5);
		ok_pull_low = 0;
		wait_mod(1, 40);
		summarize();
	end
endmodule : pol_fault_supervisor_tb_top
